/* File: verilog/sct_device.sv */
`default_nettype none
`include "sct_defs.svh"

// Summary of operation
// - column commands accepted on every clock
// - suspend begins 1 cycle after cke low
// - suspend ends 1 cycle after cke high
// - write mask blocks data on same edge
// - mask and write data share one edge
// - read mask floats output 2 cycles later
// - first write data taken with command
// - precharge floats reads after read latency
module sct_device #(
    parameter logic [`SCT_CNT_W-1:0] BURST_LEN = `SCT_BURST_LEN
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // controller pins
    input wire sct_pkg::sct_pins_s pins_i,
    output logic [`SCT_DQ_W-1:0] dq_o,
    output logic [`SCT_MASK_W-1:0] dq_oe_n_o,
    // mode setting
    input wire logic [1:0] read_latency,
    // array side
    output sct_pkg::sct_wr_s wr_o,
    output sct_pkg::sct_rd_s rd_o,
    input wire logic [`SCT_DQ_W-1:0] rd_data,
    // status
    output logic suspended_o
);
    import sct_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ****************************************
    // state update
    // ****************************************
    sct_state_s state_r;
    sct_state_s state_nxt;
    sct_pins_s p;
    logic [3:0] cmd;
    logic lat2;

    function automatic logic [3:0] live_cmd(input sct_pins_s pin, input logic susp);
        live_cmd = susp ? `SCT_CMD_NOP : pin.cmd;
    endfunction

    always_comb begin
        state_nxt = state_r;
        p = state_r.sync2;
        cmd = live_cmd(p, state_r.suspended);
        lat2 = (read_latency == `SCT_LAT_2);
        state_nxt.sync1 = pins_i;
        state_nxt.sync2 = state_r.sync1;
        state_nxt.suspended = !p.cke;
        state_nxt.wr.en = 1'b0;
        state_nxt.rd.en = 1'b0;
        case (cmd)
            `SCT_CMD_READ: begin
                state_nxt.kind = SCT_READ;
                state_nxt.col = p.col;
                state_nxt.cnt = BURST_LEN - `SCT_CNT_ONE;
                state_nxt.rd = '{en: 1'b1, col: p.col};
            end
            `SCT_CMD_WRITE: begin
                state_nxt.kind = SCT_WRITE;
                state_nxt.col = p.col;
                state_nxt.cnt = BURST_LEN - `SCT_CNT_ONE;
                state_nxt.wr = '{en: 1'b1, col: p.col, mask: p.dqm, data: p.dq};
            end
            `SCT_CMD_PRE, `SCT_CMD_STOP: begin
                state_nxt.kind = SCT_IDLE;
                state_nxt.cnt = `SCT_CNT_ZERO;
            end
            default: begin
                if (!state_r.suspended && state_r.cnt != `SCT_CNT_ZERO) begin
                    state_nxt.col = state_r.col + `SCT_COL_ONE;
                    state_nxt.cnt = state_r.cnt - `SCT_CNT_ONE;
                    if (state_r.kind == SCT_READ) begin
                        state_nxt.rd = '{en: 1'b1, col: state_nxt.col};
                    end
                    if (state_r.kind == SCT_WRITE) begin
                        state_nxt.wr = '{en: 1'b1, col: state_nxt.col, mask: p.dqm, data: p.dq};
                    end
                end
            end
        endcase
        state_nxt.rd_v2 = state_r.rd.en;
        state_nxt.rd_hold = rd_data;
        state_nxt.mask_d1 = p.dqm;
        state_nxt.dq = lat2 ? rd_data : state_r.rd_hold;
        state_nxt.dq_oe_n = ~{`SCT_MASK_W{lat2 ? state_r.rd.en : state_r.rd_v2}}
            | state_r.mask_d1;
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= '0;
            state_r.sync1.cmd <= `SCT_CMD_NOP;
            state_r.sync2.cmd <= `SCT_CMD_NOP;
            state_r.suspended <= 1'b1;
            state_r.dq_oe_n <= '1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign dq_o = state_r.dq;
    assign dq_oe_n_o = state_r.dq_oe_n;
    assign wr_o = state_r.wr;
    assign rd_o = state_r.rd;
    assign suspended_o = state_r.suspended;

    // ****************************************
    // checks
    // ****************************************
    logic rd_acc;
    logic wr_acc;
    logic pre_acc;
    logic cke_s;

    assign rd_acc = live_cmd(state_r.sync2, state_r.suspended) == `SCT_CMD_READ;
    assign wr_acc = live_cmd(state_r.sync2, state_r.suspended) == `SCT_CMD_WRITE;
    assign pre_acc = live_cmd(state_r.sync2, state_r.suspended) == `SCT_CMD_PRE;
    assign cke_s = state_r.sync2.cke;

    property p_col_every_clock;
        @(posedge clk) disable iff (!rst_n_r)
        rd_acc ##1 rd_acc |=> rd_o.en && (rd_o.col == $past(state_r.sync2.col));
    endproperty
    a_col_every_clock: assert property (p_col_every_clock) else $error("column not taken on consecutive clock");

    property p_suspend_entry;
        @(posedge clk) disable iff (!rst_n_r)
        $fell(cke_s) |=> suspended_o;
    endproperty
    a_suspend_entry: assert property (p_suspend_entry) else $error("suspend not entered one cycle after cke low");

    property p_suspend_exit;
        @(posedge clk) disable iff (!rst_n_r)
        $rose(cke_s) |=> !suspended_o;
    endproperty
    a_suspend_exit: assert property (p_suspend_exit) else $error("suspend not left one cycle after cke high");

    property p_write_mask;
        @(posedge clk) disable iff (!rst_n_r)
        wr_acc |=> wr_o.mask == $past(state_r.sync2.dqm);
    endproperty
    a_write_mask: assert property (p_write_mask) else $error("write mask not from same edge");

    property p_write_data;
        @(posedge clk) disable iff (!rst_n_r)
        wr_acc ##1 (!state_r.suspended && state_r.kind == SCT_WRITE && state_r.cnt != '0
            && state_r.sync2.cmd == `SCT_CMD_NOP) |=> wr_o.en && wr_o.data == $past(state_r.sync2.dq);
    endproperty
    a_write_data: assert property (p_write_data) else $error("burst write data not from its own edge");

    property p_read_mask;
        @(posedge clk) disable iff (!rst_n_r)
        state_r.sync2.dqm[0] |-> ##2 dq_oe_n_o[0];
    endproperty
    a_read_mask: assert property (p_read_mask) else $error("read mask did not float output two cycles later");

    property p_write_first;
        @(posedge clk) disable iff (!rst_n_r)
        wr_acc |=> wr_o.en && wr_o.data == $past(state_r.sync2.dq) && wr_o.col == $past(state_r.sync2.col);
    endproperty
    a_write_first: assert property (p_write_first) else $error("first write data not taken with command");

    property p_pre_float;
        @(posedge clk) disable iff (!rst_n_r)
        pre_acc && $stable(read_latency) |-> if (read_latency == `SCT_LAT_2) ##2 (dq_oe_n_o == '1)
            else ##3 (dq_oe_n_o == '1);
    endproperty
    a_pre_float: assert property (p_pre_float) else $error("output not floated after precharge");

    c_read: cover property (@(posedge clk) disable iff (!rst_n_r) rd_acc ##[2:3] !dq_oe_n_o[0]);
    c_write: cover property (@(posedge clk) disable iff (!rst_n_r) wr_acc ##1 wr_o.en ##1 wr_o.en);
    c_pre: cover property (@(posedge clk) disable iff (!rst_n_r) rd_acc ##1 pre_acc);
    c_susp: cover property (@(posedge clk) disable iff (!rst_n_r) suspended_o ##1 !suspended_o);

endmodule

`default_nettype wire

/* File: verilog/sct_defs.svh */
`ifndef SCT_DEFS_SVH
`define SCT_DEFS_SVH

// ****************************************
// widths
// ****************************************
`define SCT_DQ_W 16
`define SCT_MASK_W 2
`define SCT_COL_W 10
`define SCT_CNT_W 8

// ****************************************
// command codes {cs_n, ras_n, cas_n, we_n}
// ****************************************
`define SCT_CMD_READ 4'h5
`define SCT_CMD_WRITE 4'h4
`define SCT_CMD_PRE 4'h2
`define SCT_CMD_STOP 4'h6
`define SCT_CMD_NOP 4'hF

// ****************************************
// cycle figures
// ****************************************
`define SCT_LAT_2 2'h2
`define SCT_COL_CMD_GAP 1
`define SCT_BURST_LEN 8'h04
`define SCT_CNT_ONE 8'h01
`define SCT_COL_ONE 10'h001
`define SCT_CNT_ZERO 8'h00

`endif

/* File: verilog/sct_pkg.sv */
`default_nettype none
`include "sct_defs.svh"

package sct_pkg;

    typedef enum logic [1:0] {SCT_IDLE, SCT_READ, SCT_WRITE} sct_burst_e;

    // ****************************************
    // controller pins, write port, read port
    // ****************************************
    typedef struct packed {
        logic cke;
        logic [3:0] cmd;
        logic [`SCT_COL_W-1:0] col;
        logic [`SCT_MASK_W-1:0] dqm;
        logic [`SCT_DQ_W-1:0] dq;
    } sct_pins_s;

    typedef struct packed {
        logic en;
        logic [`SCT_COL_W-1:0] col;
        logic [`SCT_MASK_W-1:0] mask;
        logic [`SCT_DQ_W-1:0] data;
    } sct_wr_s;

    typedef struct packed {
        logic en;
        logic [`SCT_COL_W-1:0] col;
    } sct_rd_s;

    // ****************************************
    // whole module state
    // ****************************************
    typedef struct packed {
        sct_pins_s sync1;
        sct_pins_s sync2;
        logic suspended;
        sct_burst_e kind;
        logic [`SCT_CNT_W-1:0] cnt;
        logic [`SCT_COL_W-1:0] col;
        sct_wr_s wr;
        sct_rd_s rd;
        logic rd_v2;
        logic [`SCT_DQ_W-1:0] rd_hold;
        logic [`SCT_MASK_W-1:0] mask_d1;
        logic [`SCT_DQ_W-1:0] dq;
        logic [`SCT_MASK_W-1:0] dq_oe_n;
    } sct_state_s;

endpackage

`default_nettype wire

/* File: dv/sct_ctrl_model.sv */
`default_nettype none
`include "sct_defs.svh"

// ****************************************
// controller pin driver
// ****************************************
module sct_ctrl_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // requested pin values
    input wire sct_pkg::sct_pins_s req_i,
    // pins toward the device
    output sct_pkg::sct_pins_s pins_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import sct_pkg::*;

    // only column, precharge and stop commands reach the device
    function automatic logic [3:0] pass_cmd(input logic [3:0] c);
        case (c)
            `SCT_CMD_READ, `SCT_CMD_WRITE, `SCT_CMD_PRE, `SCT_CMD_STOP: pass_cmd = c;
            default: pass_cmd = `SCT_CMD_NOP;
        endcase
    endfunction

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pins_o <= '{cke: 1'b0, cmd: `SCT_CMD_NOP, col: 10'h000, dqm: 2'h0, dq: 16'hA5A5};
        end else begin
            pins_o <= '{cke: req_i.cke, cmd: pass_cmd(req_i.cmd), col: req_i.col,
                dqm: req_i.dqm, dq: req_i.dq};
        end
    end
endmodule

`default_nettype wire

/* File: dv/sdram_command_timing_test.sv */
`default_nettype none
`include "sct_defs.svh"

module sdram_command_timing_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sct_pkg::*;
    localparam int PIPE = 4;
    logic clk;
    logic resetn;
    logic [1:0] lat;
    logic [15:0] dq_o;
    logic [15:0] rd_data;
    logic [1:0] oe_n;
    logic susp;
    sct_pins_s req;
    sct_pins_s pins;
    sct_wr_s wr;
    sct_rd_s rd;
    int bad_count;
    int num_checks;

    // ****************************************
    // models and device
    // ****************************************
    sct_ctrl_model i_ctrl (.clk(clk), .resetn(resetn), .req_i(req), .pins_o(pins));
    sct_device i_dut (.clk(clk), .resetn(resetn), .pins_i(pins), .dq_o(dq_o), .dq_oe_n_o(oe_n),
        .read_latency(lat), .wr_o(wr), .rd_o(rd), .rd_data(rd_data), .suspended_o(susp));
    assign rd_data = rdf(rd.col);

    function automatic logic [15:0] rdf(logic [9:0] c);
        return {~c[5:0], c};
    endfunction

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    task automatic idle(int n);
        repeat (n) begin
            @(posedge clk);
            req <= '{cke: 1'b1, cmd: `SCT_CMD_NOP, col: 10'($urandom), dqm: 2'($urandom), dq: 16'($urandom)};
        end
    endtask

    task automatic do_write(logic [9:0] c);
        logic [15:0] d [4];
        logic [1:0] m [4];
        for (int i = 0; i < 4; i++) begin
            d[i] = 16'($urandom);
            m[i] = 2'($urandom);
            @(posedge clk);
            req <= '{cke: 1'b1, cmd: (i == 0) ? `SCT_CMD_WRITE : `SCT_CMD_NOP, col: c, dqm: m[i], dq: d[i]};
        end
        repeat (PIPE - 4) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            settle;
            check({wr.en, wr.col, wr.mask, wr.data}, {1'b1, c + 10'(i), m[i], d[i]});
        end
        settle;
        check(wr.en, 0);
    endtask

    task automatic do_read(logic [9:0] c, int pre_at);
        int ln;
        int i;
        logic [1:0] m [8];
        logic [1:0] e;
        logic [3:0] cut;
        ln = (lat == 2'h2) ? 2 : 3;
        cut = ($urandom_range(1) == 1) ? `SCT_CMD_PRE : `SCT_CMD_STOP;
        for (int k = 0; k < 8; k++) m[k] = 2'($urandom);
        fork
            for (int k = 0; k < 8; k++) begin
                @(posedge clk);
                req <= '{cke: 1'b1, cmd: (k == 0) ? `SCT_CMD_READ : ((k == pre_at) ? cut : `SCT_CMD_NOP),
                    col: c, dqm: m[k], dq: 16'($urandom)};
            end
            begin
                repeat (PIPE) @(posedge clk);
                for (int j = 0; j < ln + 5; j++) begin
                    settle;
                    if (j < 4 && j < pre_at) check({rd.en, rd.col}, {1'b1, c + 10'(j)});
                    else if (j < 4) check(rd.en, 0);
                    i = j - ln + 1;
                    if (i >= 0 && i < 4) begin
                        e = (i >= pre_at) ? 2'h3 : m[ln + i - 2];
                        check(oe_n, e);
                        if (e == 2'h0) check(dq_o, rdf(c + 10'(i)));
                    end else if (i >= 4) begin
                        check(oe_n, 2'h3);
                    end
                end
            end
        join
    endtask

    task automatic do_col_train(logic [9:0] c, logic is_wr);
        logic [15:0] d [5];
        logic [9:0] ec;
        for (int k = 0; k < 5; k++) d[k] = 16'($urandom);
        fork
            for (int k = 0; k < 5; k++) begin
                @(posedge clk);
                req <= '{cke: 1'b1, cmd: (k == 4) ? `SCT_CMD_NOP : (is_wr ? `SCT_CMD_WRITE : `SCT_CMD_READ),
                    col: c + 10'(4 * k), dqm: 2'h0, dq: d[k]};
            end
            begin
                repeat (PIPE) @(posedge clk);
                for (int k = 0; k < 8; k++) begin
                    settle;
                    ec = (k < 4) ? c + 10'(4 * k) : c + 10'(k + 9);
                    if (k == 7) check({rd.en, wr.en}, 2'h0);
                    else if (is_wr) check({wr.en, wr.col, wr.data}, {1'b1, ec, d[(k < 4) ? k : 4]});
                    else check({rd.en, rd.col}, {1'b1, ec});
                end
            end
        join
    endtask

    task automatic do_suspend;
        @(posedge clk);
        req.cke <= 1'b0;
        repeat (PIPE - 1) settle;
        check(susp, 0);
        settle;
        check(susp, 1);
        req.cmd <= `SCT_CMD_WRITE;
        settle;
        req.cmd <= `SCT_CMD_NOP;
        @(posedge clk);
        req.cke <= 1'b1;
        repeat (PIPE - 1) begin
            settle;
            check({susp, wr.en}, 2'h2);
        end
        settle;
        check({susp, wr.en}, 2'h0);
    endtask

    task automatic give_verdict;
        $display("checks=%0d bad=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************
    // clock, watchdog, sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #100000;
        bad_count++;
        give_verdict;
    end

    initial begin
        resetn = 1'b0;
        lat = 2'h3;
        req = '{cke: 1'b1, cmd: `SCT_CMD_NOP, col: 10'h000, dqm: 2'h0, dq: 16'h0000};
        void'($urandom(32'h2f5c));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        idle(10);
        settle;
        check(susp, 0);
        do_write(10'h3FE);
        for (int n = 0; n < 40; n++) begin
            lat <= ($urandom_range(1) == 1) ? 2'h2 : 2'h3;
            idle(3);
            case ($urandom_range(3))
                0: do_write(10'($urandom));
                1: do_read(10'($urandom), 8);
                2: do_read(10'($urandom), $urandom_range(4, 2));
                default: do_col_train(10'($urandom), 1'($urandom));
            endcase
        end
        idle(3);
        do_col_train(10'h3F8, 1'b0);
        idle(3);
        do_col_train(10'h3F8, 1'b1);
        lat <= 2'h3;
        idle(3);
        do_read(10'h100, 1);
        lat <= 2'h2;
        idle(3);
        do_read(10'h3FD, 1);
        do_suspend;
        idle(5);
        give_verdict;
    end
endmodule

`default_nettype wire
